// file: logic/irq_pkg.sv
package irq_pkg;
	localparam int NLVL = 8;
	localparam int CODE_W = 3;
	// Synchronised control pins, packed as {ack_n, cs_n, a0, wr_n, rd_n}
	localparam int CTL_W = 5;
	localparam int CTL_RD = 0;
	localparam int CTL_WR = 1;
	localparam int CTL_A0 = 2;
	localparam int CTL_CS = 3;
	localparam int CTL_ACK = 4;
	localparam logic [CTL_W-1:0] CTL_IDLE = 5'h1B;
	// Data word layouts for writes at address_select low
	localparam int INIT_BIT = 4;
	localparam int INIT_LEVEL_BIT = 3;
	localparam int INIT_AUTO_BIT = 1;
	localparam int CMD_SEL_BIT = 3;
	localparam int CMD_POLL_BIT = 2;
	localparam int CMD_RDREG_BIT = 1;
	localparam int CMD_RDISR_BIT = 0;
	localparam int CMD_EOS_BIT = 5;
	// Poll word layout
	localparam int POLL_PRESENT_BIT = 7;
	localparam logic [NLVL-1:0] POLL_EMPTY = 8'h07;
	localparam logic [CODE_W-1:0] DEFAULT_LEVEL = 3'h7;
	localparam logic [NLVL-CODE_W-1:0] VEC_UPPER = 5'h00;
	// Reset values
	localparam logic [NLVL-1:0] MASK_RESET = 8'h00;
	localparam logic [NLVL-1:0] ALL_ONES = 8'hFF;
	localparam logic [NLVL-1:0] LVL_ONE = 8'h01;
endpackage : irq_pkg

// file: logic/irq_trigger_status_poll.sv
`timescale 1ns/10ps
// Operation
// RULE_01 - Level mode: high input means pending request
// RULE_02 - Level mode: still high after clear re-interrupts
// RULE_03 - Requester holds input past first acknowledge fall
// RULE_04 - Request gone at acknowledge gives level 7
// RULE_05 - Level mode: request latch always armed
// RULE_06 - Edge mode: only rising transition sets latch
// RULE_07 - Edge mode: acknowledge disarms, low re-arms
// RULE_08 - Sensing mode from initialization, all inputs
// RULE_09 - Automatic mode clears in-service at acknowledge end
// RULE_10 - Request, in-service, mask: eight bits, readable
// RULE_11 - Read command selects register, remembered
// RULE_12 - Initialization selects request register
// RULE_13 - Mask read/write directly at address high
// RULE_14 - Poll then read acts as acknowledge
// RULE_15 - Poll word: present bit and level code
// RULE_16 - Empty poll word: present zero, code ones
// RULE_17 - Poll resolution honours priority and in-service
// RULE_18 - Host repeats poll command per read
// RULE_19 - Host disables own interrupt before polling
// RULE_20 - Host always runs full initialization
// RULE_21 - Mask bit n governs request input n
// RULE_22 - Mask gates latch output, not latch
// RULE_23 - Present bit 7, code bits 2:0, rest zero
module irq_trigger_status_poll
	import irq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [NLVL-1:0] request_input,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic cs_n,
	input wire logic address_select,
	input wire logic acknowledge_strobe_n,
	input wire logic [NLVL-1:0] data_in,
	output logic [NLVL-1:0] data_out,
	output logic data_oe,
	output logic irq_out
);

	typedef struct packed {
		logic [NLVL-1:0] req_s1;
		logic [NLVL-1:0] req_s2;
		logic [NLVL-1:0] req_prev;
		logic [NLVL-1:0] din_s1;
		logic [NLVL-1:0] din_s2;
		logic [CTL_W-1:0] ctl_s1;
		logic [CTL_W-1:0] ctl_s2;
		logic [CTL_W-1:0] ctl_prev;
		logic [NLVL-1:0] latch;
		logic [NLVL-1:0] armed;
		logic [NLVL-1:0] in_service;
		logic [NLVL-1:0] mask;
		logic level_mode;
		logic auto_eos;
		logic sel_isr;
		logic poll_pend;
		logic ack_second;
		logic [CODE_W-1:0] ack_level;
		logic [NLVL-1:0] dout;
		logic doe;
	} state_t;

	localparam state_t ST_RESET = '{
		req_s1: '0, req_s2: '0, req_prev: '0, din_s1: '0, din_s2: '0,
		ctl_s1: CTL_IDLE, ctl_s2: CTL_IDLE, ctl_prev: CTL_IDLE,
		latch: '0, armed: ALL_ONES, in_service: '0, mask: MASK_RESET,
		level_mode: 1'b0, auto_eos: 1'b0, sel_isr: 1'b0, poll_pend: 1'b0,
		ack_second: 1'b0, ack_level: '0, dout: '0, doe: 1'b0
	};

	state_t st;
	state_t next_st;

	// Levels strictly above the highest level now in service
	function automatic logic [NLVL-1:0] above_isr(input logic [NLVL-1:0] in_service_bits);
		logic [NLVL-1:0] m;
		m = ALL_ONES;
		for (int i = NLVL - 1; i >= 0; i--) begin
			if (in_service_bits[i]) begin
				m = ~(ALL_ONES << i);
			end
		end
		return m;
	endfunction : above_isr

	// Index of the highest-priority set bit, level 0 first
	function automatic logic [CODE_W-1:0] first_set(input logic [NLVL-1:0] v);
		logic [CODE_W-1:0] idx;
		idx = '0;
		for (int i = NLVL - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = CODE_W'(i);
			end
		end
		return idx;
	endfunction : first_set

	logic rd_fall;
	logic rd_end;
	logic wr_rise;
	logic ack_fall;
	logic ack_rise;
	logic ack_first;
	logic poll_take;
	logic [NLVL-1:0] eligible;
	logic pending;
	logic [CODE_W-1:0] top;
	logic [NLVL-1:0] take_clr;
	logic [NLVL-1:0] rise;
	logic [NLVL-1:0] next_latch;
	logic [NLVL-1:0] next_armed;
	logic [NLVL-1:0] eos_clr;

	// Strobe edges seen on the second sync stage against its delayed copy
	assign rd_fall = st.ctl_prev[CTL_RD] & ~st.ctl_s2[CTL_RD] & ~st.ctl_s2[CTL_CS];
	assign rd_end = ~st.ctl_prev[CTL_RD] & st.ctl_s2[CTL_RD];
	assign wr_rise = ~st.ctl_prev[CTL_WR] & st.ctl_s2[CTL_WR] & ~st.ctl_s2[CTL_CS];
	assign ack_fall = st.ctl_prev[CTL_ACK] & ~st.ctl_s2[CTL_ACK];
	assign ack_rise = ~st.ctl_prev[CTL_ACK] & st.ctl_s2[CTL_ACK];
	// The request is sampled at the first acknowledge fall, so it must still be held
	assign ack_first = ack_fall & ~st.ack_second; // RULE_03
	assign poll_take = rd_fall & st.poll_pend; // RULE_14

	// Mask gates the latch output only; priority blocks levels at or below service
	assign eligible = st.latch & ~st.mask & above_isr(st.in_service); // RULE_21 RULE_22 RULE_17
	assign pending = |eligible;
	assign top = first_set(eligible);
	assign take_clr = ((ack_first | poll_take) & pending) ? (LVL_ONE << top) : '0;
	assign eos_clr = (|st.in_service) ? (LVL_ONE << first_set(st.in_service)) : '0;

	// Per-input request latch and arming
	for (genvar i = 0; i < NLVL; i++) begin : g_req
		assign rise[i] = st.req_s2[i] & ~st.req_prev[i];
		// Level mode tracks the pin; edge mode needs a rise while armed
		assign next_latch[i] = st.level_mode ? st.req_s2[i] : // RULE_01 RULE_02 RULE_08
			(st.req_s2[i] & (st.latch[i] | (rise[i] & st.armed[i])) & ~take_clr[i]); // RULE_06
		// Taking a request disarms; a low pin re-arms; level mode never disarms
		assign next_armed[i] = st.level_mode | ~st.req_s2[i] | // RULE_05 RULE_07
			(st.armed[i] & ~take_clr[i]);
	end

	// Whole next state; write clears come before acknowledge sets so a set wins
	always_comb begin
		next_st = st;
		next_st.req_s1 = request_input;
		next_st.req_s2 = st.req_s1;
		next_st.req_prev = st.req_s2;
		next_st.din_s1 = data_in;
		next_st.din_s2 = st.din_s1;
		next_st.ctl_s1 = {acknowledge_strobe_n, cs_n, address_select, wr_n, rd_n};
		next_st.ctl_s2 = st.ctl_s1;
		next_st.ctl_prev = st.ctl_s2;
		next_st.latch = next_latch;
		next_st.armed = next_armed;
		if (wr_rise) begin
			if (st.ctl_s2[CTL_A0]) begin
				next_st.mask = st.din_s2; // RULE_13
			end else if (st.din_s2[INIT_BIT]) begin
				next_st.level_mode = st.din_s2[INIT_LEVEL_BIT]; // RULE_08
				next_st.auto_eos = st.din_s2[INIT_AUTO_BIT];
				next_st.sel_isr = 1'b0; // RULE_12
				next_st.mask = MASK_RESET;
				next_st.in_service = '0;
				next_st.poll_pend = 1'b0;
			end else if (st.din_s2[CMD_SEL_BIT]) begin
				next_st.poll_pend = st.din_s2[CMD_POLL_BIT];
				if (st.din_s2[CMD_RDREG_BIT]) begin
					next_st.sel_isr = st.din_s2[CMD_RDISR_BIT]; // RULE_11
				end
			end else if (st.din_s2[CMD_EOS_BIT]) begin
				next_st.in_service = st.in_service & ~eos_clr; // RULE_02
			end
		end
		// Acknowledge: resolve on the first fall, hand out the level on the second
		if (ack_first) begin
			// Nothing eligible any more: answer as if level 7 asked
			next_st.ack_level = pending ? top : DEFAULT_LEVEL; // RULE_04
			next_st.in_service[pending ? top : DEFAULT_LEVEL] = 1'b1; // RULE_04
			next_st.ack_second = 1'b1;
		end else if (ack_fall) begin
			next_st.dout = {VEC_UPPER, st.ack_level};
			next_st.doe = 1'b1;
		end
		if (ack_rise && st.ack_second && !st.ctl_prev[CTL_ACK] && st.doe) begin
			next_st.ack_second = 1'b0;
			next_st.doe = 1'b0;
			if (st.auto_eos) begin
				next_st.in_service[st.ack_level] = 1'b0; // RULE_09
			end
		end
		// Register and poll reads
		if (rd_fall) begin
			next_st.doe = 1'b1;
			if (st.poll_pend) begin
				// One poll command covers exactly one read
				next_st.poll_pend = 1'b0; // RULE_18
				if (pending) begin
					next_st.in_service[top] = 1'b1; // RULE_14
					next_st.dout = {1'b1, VEC_UPPER[NLVL-CODE_W-2:0], top}; // RULE_15 RULE_23
				end else begin
					next_st.dout = POLL_EMPTY; // RULE_16
				end
			end else if (st.ctl_s2[CTL_A0]) begin
				next_st.dout = st.mask; // RULE_10 RULE_13
			end else begin
				next_st.dout = st.sel_isr ? st.in_service : st.latch; // RULE_10 RULE_11
			end
		end else if (rd_end) begin
			next_st.doe = 1'b0;
		end
	end

	// Single state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign data_out = st.dout;
	assign data_oe = st.doe;
	// Interrupt line is a pure function of flops, no extra latency
	assign irq_out = pending;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_poll_full;
		poll_take && pending;
	endsequence
	sequence s_poll_empty;
		poll_take && !pending;
	endsequence
	sequence s_ack_end;
		ack_rise && st.ack_second && st.doe && st.auto_eos;
	endsequence
	sequence s_ack_second;
		ack_fall && st.ack_second;
	endsequence

	chk_level_track: assert property (st.level_mode |=> st.latch == $past(st.req_s2)) // RULE_01
		else $error("level mode latch does not follow input");

	chk_edge_lockout: assert property ((!st.level_mode && (st.req_s2 & st.req_prev & ~st.latch) != '0)
		|=> (st.latch & $past(st.req_s2 & st.req_prev & ~st.latch)) == '0) // RULE_06
		else $error("steady high set latch in edge mode");

	chk_edge_disarm: assert property ((!st.level_mode && take_clr != '0
		&& (st.req_s2 & take_clr) == take_clr)
		|=> (st.armed & $past(take_clr)) == '0 && (st.latch & $past(take_clr)) == '0) // RULE_07
		else $error("taken edge request not disarmed");

	chk_default_lvl: assert property (ack_first && !pending
		|=> st.in_service[DEFAULT_LEVEL] && st.ack_level == DEFAULT_LEVEL) // RULE_04
		else $error("default level 7 not taken");

	chk_poll_word: assert property (s_poll_full |=> data_oe && data_out[POLL_PRESENT_BIT]
		&& data_out[CODE_W-1:0] == $past(top) && st.in_service[$past(top)] && !st.poll_pend) // RULE_15
		else $error("poll word or in-service wrong");

	chk_poll_empty: assert property (s_poll_empty // RULE_16
		|=> data_oe && data_out == POLL_EMPTY ##1 !st.poll_pend)
		else $error("empty poll word wrong");

	chk_sel_init: assert property (wr_rise && !st.ctl_s2[CTL_A0] && st.din_s2[INIT_BIT]
		|=> !st.sel_isr && st.mask == MASK_RESET) // RULE_12
		else $error("read selection not reset by initialization");

	chk_mask_read: assert property (rd_fall && !st.poll_pend && st.ctl_s2[CTL_A0]
		|=> data_oe && data_out == $past(st.mask)) // RULE_13
		else $error("mask read wrong");

	chk_auto_eos: assert property (s_ack_end |=> !st.in_service[$past(st.ack_level)] && !data_oe) // RULE_09
		else $error("automatic end of service missing");

	// Acknowledge code, level-mode arming, read-back, masking and end-of-service checks
	chk_ack_word: assert property (s_ack_second |=> data_oe // RULE_04
		&& data_out == {VEC_UPPER, $past(st.ack_level)})
		else $error("acknowledge code word wrong");

	chk_ack_take: assert property (ack_first && pending // RULE_17
		|=> st.in_service[$past(top)] && st.ack_level == $past(top))
		else $error("acknowledged level not taken into service");

	chk_level_armed: assert property (st.level_mode |=> st.armed == ALL_ONES) // RULE_05
		else $error("request latch disarmed in level mode");

	chk_reg_select: assert property (rd_fall && !st.poll_pend && !st.ctl_s2[CTL_A0] // RULE_11
		|=> data_oe && data_out == ($past(st.sel_isr) ? $past(st.in_service)
		: $past(st.latch)))
		else $error("selected register read wrong");

	chk_mask_gate: assert property ((st.latch & ~st.mask) == '0 |-> !irq_out) // RULE_21 RULE_22
		else $error("masked request raised the interrupt");

	chk_eos_clear: assert property (wr_rise && !st.ctl_s2[CTL_A0] // RULE_02
		&& !st.din_s2[INIT_BIT] && !st.din_s2[CMD_SEL_BIT] && st.din_s2[CMD_EOS_BIT]
		&& !ack_first && !poll_take |=> (st.in_service & $past(eos_clr)) == '0)
		else $error("end of service left its bit set");

	chk_read_release: assert property (rd_end |=> !data_oe) // RULE_10
		else $error("data bus still driven after read");

endmodule : irq_trigger_status_poll

// file: testbench/host_cpu.sv
`timescale 1ns/10ps
// Host side of the parallel bus; every strobe moves one step after a clock edge
module host_cpu
	import irq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [NLVL-1:0] data_out,
	input wire logic data_oe,
	output logic rd_n,
	output logic wr_n,
	output logic cs_n,
	output logic address_select,
	output logic acknowledge_strobe_n,
	output logic [NLVL-1:0] data_in
);
	// Strobes idle high from time zero, through reset
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		cs_n = 1'b1;
		address_select = 1'b0;
		acknowledge_strobe_n = 1'b1;
		data_in = 8'h5A;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// Data held past the trailing edge, then the released bus shows inverted data
	task automatic wr(input logic a, input logic [NLVL-1:0] d);
		step(1);
		cs_n = 1'b0;
		address_select = a;
		data_in = d;
		wr_n = 1'b0;
		step(5);
		wr_n = 1'b1;
		step(4);
		cs_n = 1'b1;
		data_in = ~d;
		step(3);
	endtask : wr
	// A bus the device does not drive reads as the inverse of its last value
	task automatic rd(input logic a, output logic [NLVL-1:0] d);
		step(1);
		cs_n = 1'b0;
		address_select = a;
		rd_n = 1'b0;
		step(7);
		d = (data_oe === 1'b1) ? data_out : ~data_out;
		rd_n = 1'b1;
		step(4);
		cs_n = 1'b1;
		step(2);
	endtask : rd
	// Two pulses per acknowledge; the code is taken during the second
	task automatic ack(output logic [NLVL-1:0] d);
		step(1);
		acknowledge_strobe_n = 1'b0;
		step(6);
		acknowledge_strobe_n = 1'b1;
		step(4);
		acknowledge_strobe_n = 1'b0;
		step(6);
		d = (data_oe === 1'b1) ? data_out : ~data_out;
		acknowledge_strobe_n = 1'b1;
		step(8);
	endtask : ack
endmodule : host_cpu

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
	import irq_pkg::*;
	logic clk_sys;
	logic nrst;
	logic [NLVL-1:0] request_input;
	logic [NLVL-1:0] data_in;
	logic [NLVL-1:0] data_out;
	logic [NLVL-1:0] got;
	logic rd_n, wr_n, cs_n, address_select, acknowledge_strobe_n, data_oe, irq_out;
	int errors;
	int cmp_count;
	irq_trigger_status_poll dut (.clk_sys(clk_sys), .nrst(nrst), .request_input(request_input),
		.rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .address_select(address_select),
		.acknowledge_strobe_n(acknowledge_strobe_n), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .irq_out(irq_out));
	host_cpu host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n),
		.wr_n(wr_n), .cs_n(cs_n), .address_select(address_select),
		.acknowledge_strobe_n(acknowledge_strobe_n), .data_in(data_in));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic print_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [NLVL-1:0] g, input logic [NLVL-1:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// Pins pass a two-stage synchroniser, so settle a few cycles after each change
	task automatic setreq(input logic [NLVL-1:0] v);
		host.step(1);
		request_input = v;
		host.step(5);
	endtask : setreq
	// Host keeps its own interrupt input off and repeats the command for every read
	task automatic poll(input logic [NLVL-1:0] e);
		host.wr(1'b0, 8'h0C);
		host.rd(1'b0, got);
		chk(got, e);
	endtask : poll
	task automatic t_edge();
		host.wr(1'b0, 8'h10);
		setreq(8'h08);
		host.rd(1'b0, got);
		chk(got, 8'h08);
		poll(8'h83);
		host.wr(1'b0, 8'h0B);
		host.rd(1'b0, got);
		chk(got, 8'h08);
		host.rd(1'b0, got);
		chk(got, 8'h08);
		// Back to the request register: the held-high level stays locked out
		host.wr(1'b0, 8'h0A);
		host.rd(1'b0, got);
		chk(got, 8'h00);
		host.wr(1'b0, 8'h20);
		poll(POLL_EMPTY);
		setreq(8'h00);
		setreq(8'h08);
		poll(8'h83);
		host.wr(1'b0, 8'h20);
		setreq(8'h00);
	endtask : t_edge
	task automatic t_level();
		host.wr(1'b0, 8'h18);
		setreq(8'h20);
		host.rd(1'b0, got);
		chk(got, 8'h20);
		poll(8'h85);
		host.wr(1'b0, 8'h20);
		poll(8'h85);
		host.wr(1'b0, 8'h20);
		host.wr(1'b1, 8'h20);
		host.rd(1'b1, got);
		chk(got, 8'h20);
		host.rd(1'b0, got);
		chk(got, 8'h20);
		chk({7'h00, irq_out}, 8'h00);
		host.wr(1'b1, MASK_RESET);
		chk({7'h00, irq_out}, LVL_ONE);
		setreq(8'h24);
		poll(8'h82);
		// Level 2 in service blocks the lower level 5
		poll(POLL_EMPTY);
		host.wr(1'b0, 8'h20);
		setreq(8'h20);
		poll(8'h85);
		host.wr(1'b0, 8'h20);
	endtask : t_level
	task automatic t_ack();
		host.wr(1'b0, 8'h1A);
		setreq(8'h10);
		// Request stays high well past the first acknowledge fall
		host.ack(got);
		chk(got, {VEC_UPPER, 3'h4});
		host.wr(1'b0, 8'h0B);
		host.rd(1'b0, got);
		chk(got, 8'h00);
		host.wr(1'b0, 8'h10);
		setreq(8'h00);
		setreq(8'h02);
		setreq(8'h00);
		host.ack(got);
		chk(got, {VEC_UPPER, DEFAULT_LEVEL});
	endtask : t_ack
	// Watchdog: the sequence needs some 660 cycles, far below the 12500 of the limit
	initial begin
		#100_000;
		errors++;
		print_verdict();
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		nrst = 1'b0;
		request_input = 8'h00;
		repeat (20) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		host.step(3);
		t_edge();
		t_level();
		t_ack();
		print_verdict();
	end
endmodule : tb
